// *** include/ard_defines.vh ***
// Purpose: shared constants of the converter result, monitor-one and dma request register block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: offsets are byte addresses
`ifndef ARD_DEFINES_VH
`define ARD_DEFINES_VH

// register byte offsets
`define ARD_OFS_MON1_CFG 8'h00
`define ARD_OFS_DMA_EN 8'h04
`define ARD_OFS_INT_STATUS 8'h08
`define ARD_OFS_INT_MASK 8'h0c
`define ARD_OFS_RESULT_BASE 8'h10
`define ARD_OFS_PRIORITY 8'h40

// monitor_one_config fields
`define ARD_MON1_EN_BIT 0
`define ARD_MON1_SEL_LSB 1
`define ARD_MON1_SEL_MSB 4
`define ARD_MON1_DIR_BIT 5
`define ARD_MON1_CFG_W 6

// dma_request_enables fields
`define ARD_DMA_NORMAL_BIT 0
`define ARD_DMA_PRIORITY_BIT 1
`define ARD_DMA_MON0_BIT 2
`define ARD_DMA_MON1_BIT 3
`define ARD_DMA_W 4

// interrupt status and mask share this layout
`define ARD_EV_NORMAL 0
`define ARD_EV_PRIORITY 1
`define ARD_EV_MON0 2
`define ARD_EV_MON1 3
`define ARD_EV_W 4

// result register fields
`define ARD_RES_VAL_LSB 6
`define ARD_RES_VAL_MSB 15
`define ARD_RES_OVR_BIT 1
`define ARD_RES_STORED_BIT 0

// reset values
`define ARD_RST_MON1_CFG 6'h00
`define ARD_RST_DMA_EN 4'h0
`define ARD_RST_INT 4'h0
`define ARD_RST_RESULT 10'h000

`endif

// *** hw/ard_top.v ***
// Purpose: result registers, monitor-one compare, dma request enables and interrupt status behind apb
// Assumes: conversion engine strobes and monitor-zero event come from logic on clk
// Notes: zero wait state apb slave, registered read data
//
// Overview of operation
// (RL1) direction bit: 0 below, 1 above value
// (RL2) target code 0-7 normal, 1xxx priority result
// (RL3) monitor one acts only when enabled
// (RL4) bit 3 lets monitor-one event request dma
// (RL5) bit 2 lets monitor-zero event request dma
// (RL6) bit 1 lets priority completion request dma
// (RL7) bit 0 lets normal completion request dma
// (RL8) twelve normal results, value bits 15:6
// (RL9) overrun set when unread result overwritten
// (RL10) reading result clears overrun flag
// (RL11) stored flag set on every result write
// (RL12) reading result clears stored flag
// (RL13) software uses only halfword or word accesses
// (RL14) all configuration and results zero after reset
// (RL15) priority result behaves like normal results
// (RL16) compare on each write into target register
`timescale 1ns/1ps
`default_nettype none
`include "ard_defines.vh"

module ard_top #(
  parameter NUM_RESULTS = 12,
  parameter RES_W = 10
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire normal_wr,
  input wire [3:0] normal_wr_idx,
  input wire [RES_W-1:0] normal_wr_data,
  input wire normal_done,
  input wire priority_wr,
  input wire [RES_W-1:0] priority_wr_data,
  input wire [RES_W-1:0] cmp1_value,
  input wire mon0_event,
  output reg mon1_irq,
  output reg normal_dma_req,
  output reg priority_dma_req,
  output reg mon0_dma_req,
  output reg mon1_dma_req,
  output reg irq
);

  // configuration
  reg [`ARD_MON1_CFG_W-1:0] monitor_one_config;
  reg [`ARD_DMA_W-1:0] dma_request_enables;
  reg [`ARD_EV_W-1:0] int_status;
  reg [`ARD_EV_W-1:0] int_mask;

  // result storage
  reg [RES_W-1:0] result_value [0:NUM_RESULTS-1];
  reg [NUM_RESULTS-1:0] result_overrun;
  reg [NUM_RESULTS-1:0] result_stored;
  reg [RES_W-1:0] priority_value;
  reg priority_overrun;
  reg priority_stored;

  // decoded configuration fields
  wire mon1_enable;
  wire mon1_direction;
  wire [3:0] mon1_target_sel;
  wire mon1_dma_en;
  wire mon0_dma_en;
  wire priority_dma_en;
  wire normal_dma_en;

  assign mon1_enable = monitor_one_config[`ARD_MON1_EN_BIT];
  assign mon1_direction = monitor_one_config[`ARD_MON1_DIR_BIT];
  assign mon1_target_sel = monitor_one_config[`ARD_MON1_SEL_MSB:`ARD_MON1_SEL_LSB];
  assign mon1_dma_en = dma_request_enables[`ARD_DMA_MON1_BIT];
  assign mon0_dma_en = dma_request_enables[`ARD_DMA_MON0_BIT];
  assign priority_dma_en = dma_request_enables[`ARD_DMA_PRIORITY_BIT];
  assign normal_dma_en = dma_request_enables[`ARD_DMA_NORMAL_BIT];

  // bus phases
  wire setup_phase;
  wire access_done;
  wire wr_done;
  wire rd_done;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_done = access_done & pwrite;
  assign rd_done = access_done & ~pwrite;

  // address decode
  wire [7:0] res_ofs;
  wire res_hit;
  wire [3:0] res_idx;
  wire prio_hit;
  wire mapped;

  assign res_ofs = paddr - `ARD_OFS_RESULT_BASE;
  assign res_hit = (paddr >= `ARD_OFS_RESULT_BASE) && (paddr < `ARD_OFS_PRIORITY) &&
                   (paddr[1:0] == 2'h0);
  assign res_idx = res_ofs[5:2];
  assign prio_hit = (paddr == `ARD_OFS_PRIORITY);
  assign mapped = (paddr == `ARD_OFS_MON1_CFG) || (paddr == `ARD_OFS_DMA_EN) ||
                  (paddr == `ARD_OFS_INT_STATUS) || (paddr == `ARD_OFS_INT_MASK) ||
                  res_hit || prio_hit;

  // a result written at the setup edge is newer than the captured read data,
  // so the read that completes next must leave its flags set
  reg res_fresh;
  reg prio_fresh;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      res_fresh <= 1'b0;
      prio_fresh <= 1'b0;
    end else begin
      res_fresh <= setup_phase & res_hit & normal_wr & (normal_wr_idx == res_idx);
      prio_fresh <= setup_phase & prio_hit & priority_wr;
    end
  end

  // result reads that clear flags
  wire res_read;
  wire prio_read;

  // (RL10) read clears flags unless overtaken
  assign res_read = rd_done & res_hit & ~res_fresh;
  assign prio_read = rd_done & prio_hit & ~prio_fresh;

  // monitor-one compare on the incoming value
  reg mon1_hit_target;
  reg [RES_W-1:0] mon1_sample;
  reg mon1_cond;
  wire mon1_event;

  always @* begin
    mon1_hit_target = 1'b0;
    mon1_sample = normal_wr_data;
    // (RL2) target register select
    if (mon1_target_sel[3]) begin
      mon1_hit_target = priority_wr;
      mon1_sample = priority_wr_data;
    end else begin
      mon1_hit_target = normal_wr && (normal_wr_idx == {1'b0, mon1_target_sel[2:0]});
      mon1_sample = normal_wr_data;
    end
    // (RL1) compare direction
    if (mon1_direction) begin
      mon1_cond = (mon1_sample > cmp1_value);
    end else begin
      mon1_cond = (mon1_sample < cmp1_value);
    end
  end

  // (RL3) gated by enable
  // (RL16) one pulse per target write
  assign mon1_event = mon1_enable & mon1_hit_target & mon1_cond;

  // event vector for the status register
  wire [`ARD_EV_W-1:0] events;

  assign events[`ARD_EV_NORMAL] = normal_done;
  assign events[`ARD_EV_PRIORITY] = priority_wr;
  assign events[`ARD_EV_MON0] = mon0_event;
  assign events[`ARD_EV_MON1] = mon1_event;

  // read data mux, evaluated in the setup cycle
  reg [31:0] next_prdata;

  always @* begin
    next_prdata = 32'h0000_0000;
    if (res_hit && (res_idx < NUM_RESULTS)) begin
      next_prdata[`ARD_RES_VAL_MSB:`ARD_RES_VAL_LSB] = result_value[res_idx];
      next_prdata[`ARD_RES_OVR_BIT] = result_overrun[res_idx];
      next_prdata[`ARD_RES_STORED_BIT] = result_stored[res_idx];
    end else if (prio_hit) begin
      next_prdata[`ARD_RES_VAL_MSB:`ARD_RES_VAL_LSB] = priority_value;
      next_prdata[`ARD_RES_OVR_BIT] = priority_overrun;
      next_prdata[`ARD_RES_STORED_BIT] = priority_stored;
    end else begin
      case (paddr)
        `ARD_OFS_MON1_CFG: begin
          next_prdata[`ARD_MON1_CFG_W-1:0] = monitor_one_config;
        end
        `ARD_OFS_DMA_EN: begin
          next_prdata[`ARD_DMA_W-1:0] = dma_request_enables;
        end
        `ARD_OFS_INT_STATUS: begin
          next_prdata[`ARD_EV_W-1:0] = int_status;
        end
        `ARD_OFS_INT_MASK: begin
          next_prdata[`ARD_EV_W-1:0] = int_mask;
        end
        default: begin
          next_prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // apb handshake: answer in the first access cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_phase;
      // unmapped addresses answer with an error and zero data
      pslverr <= setup_phase & ~mapped;
      if (setup_phase) begin
        prdata <= next_prdata;
      end
    end
  end

  // software writable registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      // (RL14) configuration cleared
      monitor_one_config <= `ARD_RST_MON1_CFG;
      dma_request_enables <= `ARD_RST_DMA_EN;
      int_mask <= `ARD_RST_INT;
    end else if (wr_done) begin
      case (paddr)
        `ARD_OFS_MON1_CFG: begin
          monitor_one_config <= pwdata[`ARD_MON1_CFG_W-1:0];
        end
        `ARD_OFS_DMA_EN: begin
          dma_request_enables <= pwdata[`ARD_DMA_W-1:0];
        end
        `ARD_OFS_INT_MASK: begin
          int_mask <= pwdata[`ARD_EV_W-1:0];
        end
        default: begin
          monitor_one_config <= monitor_one_config;
        end
      endcase
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  wire [`ARD_EV_W-1:0] status_clear;

  assign status_clear = (wr_done && (paddr == `ARD_OFS_INT_STATUS)) ?
                        pwdata[`ARD_EV_W-1:0] : {`ARD_EV_W{1'b0}};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      int_status <= `ARD_RST_INT;
      irq <= 1'b0;
    end else begin
      int_status <= (int_status & ~status_clear) | events;
      irq <= |(((int_status & ~status_clear) | events) & int_mask);
    end
  end

  // normal result registers
  integer i;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      // (RL14) results and flags cleared
      for (i = 0; i < NUM_RESULTS; i = i + 1) begin
        result_value[i] <= `ARD_RST_RESULT;
      end
      result_overrun <= {NUM_RESULTS{1'b0}};
      result_stored <= {NUM_RESULTS{1'b0}};
    end else begin
      for (i = 0; i < NUM_RESULTS; i = i + 1) begin
        if (normal_wr && (normal_wr_idx == i[3:0])) begin
          // (RL8) ten-bit result held
          result_value[i] <= normal_wr_data;
          // (RL11) stored flag set
          result_stored[i] <= 1'b1;
          // (RL9) unread value overwritten
          if (result_stored[i] && !(res_read && (res_idx == i[3:0]))) begin
            result_overrun[i] <= 1'b1;
          end else if (res_read && (res_idx == i[3:0])) begin
            result_overrun[i] <= 1'b0;
          end
        end else if (res_read && (res_idx == i[3:0])) begin
          // (RL10) read clears overrun
          result_overrun[i] <= 1'b0;
          // (RL12) read clears stored
          result_stored[i] <= 1'b0;
        end
      end
    end
  end

  // priority result register
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      priority_value <= `ARD_RST_RESULT;
      priority_overrun <= 1'b0;
      priority_stored <= 1'b0;
    end else begin
      // (RL15) same flag behaviour as normal results
      if (priority_wr) begin
        priority_value <= priority_wr_data;
        priority_stored <= 1'b1;
        if (priority_stored && !prio_read) begin
          priority_overrun <= 1'b1;
        end else if (prio_read) begin
          priority_overrun <= 1'b0;
        end
      end else if (prio_read) begin
        priority_overrun <= 1'b0;
        priority_stored <= 1'b0;
      end
    end
  end

  // event pulses and dma requests, one cycle after the cause
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mon1_irq <= 1'b0;
      normal_dma_req <= 1'b0;
      priority_dma_req <= 1'b0;
      mon0_dma_req <= 1'b0;
      mon1_dma_req <= 1'b0;
    end else begin
      mon1_irq <= mon1_event;
      // (RL4) monitor-one dma request
      mon1_dma_req <= mon1_event & mon1_dma_en;
      // (RL5) monitor-zero dma request
      mon0_dma_req <= mon0_event & mon0_dma_en;
      // (RL6) priority completion dma request
      priority_dma_req <= priority_wr & priority_dma_en;
      // (RL7) normal completion dma request
      normal_dma_req <= normal_done & normal_dma_en;
    end
  end

endmodule
`default_nettype wire

// *** testbench/ard_dma_model.sv ***
// Purpose: dma controller side of ard_top
// Assumes: requests are one-cycle pulses on clk
// Notes: a counter per channel, order normal, priority, mon0, mon1
`timescale 1ns/1ps
`default_nettype none
module ard_dma_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] req,
  output var int cnt [4]
);
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (rst) cnt[i] <= 0;
      else if (req[i] === 1'b1) cnt[i] <= cnt[i] + 1;
    end
  end
endmodule
`default_nettype wire

// *** testbench/ard_chk.sv ***
// Purpose: port-level assertions on ard_top
// Assumes: one clock, async high reset
// Notes: normal, priority and mon0 request pulses are traced back to their cause one cycle earlier, mon1 requests to mon1_irq in the same cycle
`timescale 1ns/1ps
`default_nettype none
module ard_chk #(
  parameter NUM_RESULTS = 12,
  parameter RES_W = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic normal_wr,
  input wire logic normal_done,
  input wire logic priority_wr,
  input wire logic mon0_event,
  input wire logic mon1_irq,
  input wire logic normal_dma_req,
  input wire logic priority_dma_req,
  input wire logic mon0_dma_req,
  input wire logic mon1_dma_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_m1dma; mon1_dma_req |-> mon1_irq; endproperty
  a_m1dma: assert property (p_m1dma) else $error("mon1 dma without irq");
  property p_m0dma; mon0_dma_req |-> $past(mon0_event); endproperty
  a_m0dma: assert property (p_m0dma) else $error("mon0 dma without event");
  property p_hpdma; priority_dma_req |-> $past(priority_wr); endproperty
  a_hpdma: assert property (p_hpdma) else $error("priority dma without done");
  property p_nrdma; normal_dma_req |-> $past(normal_done); endproperty
  a_nrdma: assert property (p_nrdma) else $error("normal dma without done");
  property p_m1src; mon1_irq |-> $past(normal_wr || priority_wr); endproperty
  a_m1src: assert property (p_m1src) else $error("mon1 irq without write");
  property p_resz; pready && !pwrite && paddr >= 8'h10 |-> prdata[31:16] == 16'h0 && prdata[5:2] == 4'h0; endproperty
  a_resz: assert property (p_resz) else $error("result spare bits set");
  property p_cfgz; pready && !pwrite && paddr == 8'h00 |-> prdata[31:6] == 26'h0; endproperty
  a_cfgz: assert property (p_cfgz) else $error("config spare bits set");
  property p_dmaz; pready && !pwrite && paddr == 8'h04 |-> prdata[31:4] == 28'h0; endproperty
  a_dmaz: assert property (p_dmaz) else $error("dma spare bits set");
  c_irq: cover property (mon1_irq);
  c_dma: cover property (mon1_dma_req);
  c_err: cover property (pslverr);
endmodule
bind ard_top ard_chk #(.NUM_RESULTS(NUM_RESULTS), .RES_W(RES_W)) i_ard_chk (.clk, .rst, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .normal_wr, .normal_done, .priority_wr, .mon0_event, .mon1_irq,
  .normal_dma_req, .priority_dma_req, .mon0_dma_req, .mon1_dma_req);
`default_nettype wire

// *** testbench/ard_tb_top.sv ***
// Purpose: self-checking bench for ard_top
// Assumes: apb master and conversion strobes driven here
// Notes: flags, status and request counts mirrored in an integer model
`timescale 1ns/1ps
`default_nettype none
`include "ard_defines.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module ard_tb_top;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic normal_wr = 0, normal_done = 0, priority_wr = 0, mon0_event = 0;
  logic pready, pslverr, mon1_irq, irq;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] idx = 0;
  wire [3:0] req;
  logic [9:0] wd = 0, cmp = 0;
  int cnt [4];
  int bad_count = 0, checks_done = 0, cyc = 0, n_irq = 0, e_irq = 0, e_cnt [4];
  int val [13], ovr [13], st [13];
  int cfg = 0, dma = 0, stat = 0, t, v;
  always #20 clk = ~clk;
  ard_top i_ard_top (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .normal_wr, .normal_wr_idx(idx), .normal_wr_data(wd), .normal_done, .priority_wr, .priority_wr_data(wd),
    .cmp1_value(cmp), .mon0_event, .mon1_irq, .normal_dma_req(req[0]), .priority_dma_req(req[1]),
    .mon0_dma_req(req[2]), .mon1_dma_req(req[3]), .irq);
  ard_dma_model i_ard_dma_model (.clk, .rst, .req, .cnt);
  always @(posedge clk) begin
    cyc++;
    if (mon1_irq === 1'b1) n_irq++;
    if (cyc == 20000) begin
      bad_count++;
      close_out;
    end
  end
  task close_out;
    $display("counts: %0d checks, %0d mismatches", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // whole-word transfers only, no byte lanes
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdres(input int n);
    apb(0, n < 12 ? `ARD_OFS_RESULT_BASE + 8'(4 * n) : `ARD_OFS_PRIORITY, 0);
    `CHK(rd, 32'((val[n] << 6) | (ovr[n] << 1) | st[n]))
    ovr[n] = 0;
    st[n] = 0;
  endtask
  task conv(input int n, input int d);
    int s;
    @(posedge clk);
    idx <= 4'(n);
    wd <= 10'(d);
    if (n == 12) priority_wr <= 1;
    else normal_wr <= 1;
    @(posedge clk);
    normal_wr <= 0;
    priority_wr <= 0;
    s = (cfg >> 1) % 16;
    if (n < 13) begin
      ovr[n] |= st[n];
      st[n] = 1;
      val[n] = d;
    end
    if (n == 12) begin
      stat |= 2;
      e_cnt[1] += dma[1];
    end
    if (cfg[0] && n == (s > 7 ? 12 : s) && (cfg[5] ? d > cmp : d < cmp)) begin
      e_irq++;
      stat |= 8;
      e_cnt[3] += dma[3];
    end
  endtask
  task ev(input int b);
    @(posedge clk);
    normal_done <= b == 0;
    mon0_event <= b == 2;
    @(posedge clk);
    normal_done <= 0;
    mon0_event <= 0;
    stat |= 1 << b;
    e_cnt[b] += dma[b];
  endtask
  initial begin
    void'($urandom(70));
    repeat (6) @(posedge clk);
    rst <= 0;
    apb(0, `ARD_OFS_MON1_CFG, 0);
    `CHK(rd, 32'h0)
    apb(0, `ARD_OFS_DMA_EN, 0);
    `CHK(rd, 32'h0)
    for (int n = 0; n < 13; n++) rdres(n);
    $display("reset test done");
    // idx 13 to 15 must not land anywhere
    for (int n = 0; n < 16; n++) begin
      conv(n, $urandom % 1024);
      conv(n, $urandom % 1024);
      if (n < 13) rdres(n);
      if (n < 13) rdres(n);
    end
    for (int n = 0; n < 13; n++) rdres(n);
    $display("result test done");
    for (int k = 0; k < 32; k++) begin
      cfg = (($urandom % 2) << 5) | ((k % 16) << 1) | (k < 24);
      dma = $urandom % 16;
      cmp <= 10'($urandom);
      apb(1, `ARD_OFS_MON1_CFG, cfg);
      apb(1, `ARD_OFS_DMA_EN, dma);
      apb(0, `ARD_OFS_MON1_CFG, 0);
      `CHK(rd, 32'(cfg))
      `CHK(err, 1'b0)
      apb(0, `ARD_OFS_DMA_EN, 0);
      `CHK(rd, 32'(dma))
      t = (k % 16) > 7 ? 12 : k % 16;
      v = k % 5 == 0 ? int'(cmp) : $urandom % 1024;
      conv(t, v);
      conv(11 - k % 2, v);
      ev(0);
      ev(2);
      repeat (2) @(posedge clk);
      `CHK(n_irq, e_irq)
      for (int i = 0; i < 4; i++) `CHK(cnt[i], e_cnt[i])
    end
    $display("monitor test done");
    @(negedge clk);
    `CHK(irq, 1'b0)
    apb(0, `ARD_OFS_INT_STATUS, 0);
    `CHK(rd, 32'(stat))
    apb(1, `ARD_OFS_INT_MASK, 32'hf);
    @(posedge clk);
    @(negedge clk);
    `CHK(irq, stat != 0)
    apb(1, `ARD_OFS_INT_STATUS, 32'hf);
    @(posedge clk);
    @(negedge clk);
    `CHK(irq, 1'b0)
    apb(0, 8'h44, 0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    $display("interrupt test done");
    close_out;
  end
endmodule
`default_nettype wire
